// file: inc/dmacs_regs.svh
// Register map, field positions and reset values of the channel status block.
// Assumes a 32-bit APB slave; byte address is four times the register index.
`ifndef DMACS_REGS_SVH
`define DMACS_REGS_SVH

// ***********************************************
// Register indices
// ***********************************************
`define DMACS_IDX_CTRL      10'h0C0
`define DMACS_IDX_CMD       10'h0C2
`define DMACS_IDX_STATE     10'h0C4
`define DMACS_IDX_FLAGS     10'h0C6
`define DMACS_IDX_PTR       10'h0D0
`define DMACS_IDX_CNT       10'h0D2
`define DMACS_IDX_CAP_PTR   10'h0D4
`define DMACS_IDX_CAP_CNT   10'h0D6

// ***********************************************
// Widths and fields
// ***********************************************
`define DMACS_PTR_W         20
`define DMACS_CNT_W         16
`define DMACS_CTRL_W        6
`define DMACS_CTRL_IDLE_IE  0
`define DMACS_CTRL_DRAIN_IE 1
`define DMACS_CTRL_PAUSE    2
`define DMACS_CTRL_REQ_POL  3
`define DMACS_CTRL_ACK_POL  4
`define DMACS_CTRL_SLAVE    5
`define DMACS_CMD_START     0
`define DMACS_FL_IDLE       0
`define DMACS_FL_DRAIN      1
`define DMACS_FL_TRANSFER_PARITY_FLAG       2
`define DMACS_FL_LATE       3
`define DMACS_FL_REJ        4
`define DMACS_FL_PIOE       5
`define DMACS_FL_PIOPE      6
`define DMACS_FL_ANY        7
`define DMACS_CTRL_RST      6'h00
`define DMACS_FLAGS_RST     7'h00

`endif

// file: inc/dmacs_pkg.sv
// Types shared by the channel status block.
// Assumes dmacs_regs.svh is compiled alongside.
package dmacs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_FULL = 3'b100
    } dmacs_state_e;

endpackage : dmacs_pkg

// file: verilog/dmacs_sync.sv
// Two-stage synchroniser for the request and acknowledge pins.
// Assumes asynchronous pin levels; clk_sys domain only.
`timescale 1ns/1ps
`default_nettype none

module dmacs_sync (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic [1:0] pin_in,
    output logic      [1:0] pin_sync
);

    logic [1:0] stage1_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage1_reg <= 2'h0;
            pin_sync   <= 2'h0;
        end else begin
            stage1_reg <= pin_in;
            pin_sync   <= stage1_reg;
        end
    end

endmodule : dmacs_sync

`default_nettype wire

// file: verilog/dmacs_top.sv
// Status and event flags of one DMA channel, with APB register access.
// Assumes same-clock event pulses from the transfer logic and async pins.
`timescale 1ns/1ps
`default_nettype none
`include "dmacs_regs.svh"

module dmacs_top (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        peripheral_request,
    input  wire logic        peripheral_acknowledge,
    input  wire logic        fifo_empty_status,
    input  wire logic        xfer_byte,
    input  wire logic        fifo_late_event,
    input  wire logic        xfer_parity_event,
    input  wire logic        pio_active,
    input  wire logic        chan_reset_active,
    input  wire logic        pio_request,
    input  wire logic        pio_parity_event,
    output logic             channel_active_status,
    output logic             pipeline_full_status,
    output logic             chan_irq
);

    // ***********************************************
    // Decode
    // ***********************************************
    function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    dmacs_pkg::dmacs_state_e  state_reg;
    logic [`DMACS_CTRL_W-1:0] ctrl_reg;
    logic [6:0]               flag_reg;
    logic [6:0]               flag_set;
    logic [6:0]               flag_clr;
    logic [`DMACS_PTR_W-1:0]  ptr_reg;
    logic [`DMACS_CNT_W-1:0]  cnt_reg;
    logic [`DMACS_PTR_W-1:0]  nxt_ptr_reg;
    logic [`DMACS_CNT_W-1:0]  nxt_cnt_reg;
    logic [`DMACS_PTR_W-1:0]  cap_ptr_reg;
    logic [`DMACS_CNT_W-1:0]  cap_cnt_reg;
    logic                     discard_reg;
    logic                     active_d_reg;
    logic                     full_d_reg;
    logic [1:0]               pin_sync;
    logic                     wr_acc;
    logic                     setup;
    logic                     mapped;
    logic                     wr_ctrl;
    logic                     wr_flags;
    logic                     wr_ptr;
    logic                     wr_cnt;
    logic                     start_wr;
    logic                     err_block;
    logic                     refuse;
    logic                     accept;
    logic                     done;
    logic                     reload;
    logic                     req_state;
    logic                     ack_state;
    logic                     any_err;
    logic [7:0]               state_bits;
    logic [7:0]               flags_rd;
    logic [31:0]              rd_next;

    dmacs_sync u_sync (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .pin_in   ({peripheral_acknowledge, peripheral_request}),
        .pin_sync (pin_sync)
    );

    assign setup    = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign mapped   = hit(paddr, `DMACS_IDX_CTRL) || hit(paddr, `DMACS_IDX_CMD)
                   || hit(paddr, `DMACS_IDX_STATE) || hit(paddr, `DMACS_IDX_FLAGS)
                   || hit(paddr, `DMACS_IDX_PTR) || hit(paddr, `DMACS_IDX_CNT)
                   || hit(paddr, `DMACS_IDX_CAP_PTR) || hit(paddr, `DMACS_IDX_CAP_CNT);
    assign wr_ctrl  = wr_acc && hit(paddr, `DMACS_IDX_CTRL);
    assign wr_flags = wr_acc && hit(paddr, `DMACS_IDX_FLAGS);
    assign wr_ptr   = wr_acc && hit(paddr, `DMACS_IDX_PTR);
    assign wr_cnt   = wr_acc && hit(paddr, `DMACS_IDX_CNT);
    assign start_wr = wr_acc && hit(paddr, `DMACS_IDX_CMD) && pwdata[`DMACS_CMD_START];

    // ***********************************************
    // Channel state
    // ***********************************************
    assign channel_active_status = (state_reg != dmacs_pkg::ST_IDLE);
    assign pipeline_full_status  = (state_reg == dmacs_pkg::ST_FULL);
    assign err_block = flag_reg[`DMACS_FL_TRANSFER_PARITY_FLAG] || flag_reg[`DMACS_FL_LATE];
    assign refuse    = start_wr && (pipeline_full_status || err_block);
    assign accept    = start_wr && !refuse;
    assign done      = channel_active_status && xfer_byte && (cnt_reg == 16'h0001);
    // Pipeline taken only if not discarded and no parity stop pending
    assign reload    = done && pipeline_full_status && !discard_reg
                    && !flag_reg[`DMACS_FL_TRANSFER_PARITY_FLAG];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= dmacs_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                dmacs_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_reg <= dmacs_pkg::ST_BUSY;
                    end
                end
                dmacs_pkg::ST_BUSY: begin
                    if (done) begin
                        state_reg <= dmacs_pkg::ST_IDLE;
                    end else if (accept) begin
                        state_reg <= dmacs_pkg::ST_FULL;
                    end
                end
                dmacs_pkg::ST_FULL: begin
                    if (reload) begin
                        state_reg <= dmacs_pkg::ST_BUSY;
                    end else if (done) begin
                        state_reg <= dmacs_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            discard_reg <= 1'b0;
        end else if (done) begin
            discard_reg <= 1'b0;
        end else if (refuse && channel_active_status) begin
            discard_reg <= 1'b1;
        end
    end

    // ***********************************************
    // Pointer and counter, pipeline copies
    // ***********************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ptr_reg <= 20'h00000;
            cnt_reg <= 16'h0000;
        end else if (reload) begin
            ptr_reg <= nxt_ptr_reg;
            cnt_reg <= nxt_cnt_reg;
        end else begin
            if (channel_active_status && xfer_byte) begin
                ptr_reg <= ptr_reg + 20'h00001;
                cnt_reg <= cnt_reg - 16'h0001;
            end else if (!channel_active_status) begin
                if (wr_ptr) begin
                    ptr_reg <= pwdata[`DMACS_PTR_W-1:0];
                end
                if (wr_cnt) begin
                    cnt_reg <= pwdata[`DMACS_CNT_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            nxt_ptr_reg <= 20'h00000;
            nxt_cnt_reg <= 16'h0000;
        end else if (state_reg == dmacs_pkg::ST_BUSY) begin
            if (wr_ptr) begin
                nxt_ptr_reg <= pwdata[`DMACS_PTR_W-1:0];
            end
            if (wr_cnt) begin
                nxt_cnt_reg <= pwdata[`DMACS_CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cap_ptr_reg <= 20'h00000;
            cap_cnt_reg <= 16'h0000;
        end else if (xfer_parity_event || (fifo_late_event && !ctrl_reg[`DMACS_CTRL_PAUSE])) begin
            cap_ptr_reg <= ptr_reg;
            cap_cnt_reg <= cnt_reg;
        end
    end

    // ***********************************************
    // Control register
    // ***********************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_reg <= `DMACS_CTRL_RST;
        end else if (wr_ctrl && !channel_active_status) begin
            ctrl_reg <= pwdata[`DMACS_CTRL_W-1:0];
        end
    end

    // ***********************************************
    // Event flags
    // ***********************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            active_d_reg <= 1'b0;
            full_d_reg   <= 1'b0;
        end else begin
            active_d_reg <= channel_active_status;
            full_d_reg   <= pipeline_full_status;
        end
    end

    always_comb begin
        flag_set = 7'h00;
        flag_set[`DMACS_FL_IDLE]  = ctrl_reg[`DMACS_CTRL_IDLE_IE]
                                 && active_d_reg && !channel_active_status;
        flag_set[`DMACS_FL_DRAIN] = ctrl_reg[`DMACS_CTRL_DRAIN_IE]
                                 && full_d_reg && !pipeline_full_status;
        flag_set[`DMACS_FL_TRANSFER_PARITY_FLAG]  = xfer_parity_event;
        flag_set[`DMACS_FL_LATE]  = fifo_late_event && channel_active_status
                                 && !ctrl_reg[`DMACS_CTRL_PAUSE];
        flag_set[`DMACS_FL_REJ]   = refuse;
        flag_set[`DMACS_FL_PIOE]  = (pio_request && ctrl_reg[`DMACS_CTRL_SLAVE])
                                 || (wr_ctrl && channel_active_status);
        flag_set[`DMACS_FL_PIOPE] = pio_parity_event;
    end

    assign flag_clr = wr_flags ? pwdata[6:0] : 7'h00;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flag_reg <= `DMACS_FLAGS_RST;
        end else begin
            flag_reg <= (flag_reg & ~flag_clr) | flag_set;
        end
    end

    assign any_err  = |flag_reg[6:2];
    assign chan_irq = |flag_reg;

    // ***********************************************
    // Read path
    // ***********************************************
    assign req_state  = pin_sync[0] ^ ctrl_reg[`DMACS_CTRL_REQ_POL];
    assign ack_state  = pin_sync[1] ^ ctrl_reg[`DMACS_CTRL_ACK_POL];
    assign state_bits = {2'b00, ack_state, req_state,
                         pio_active || chan_reset_active,
                         fifo_empty_status,
                         pipeline_full_status, channel_active_status};
    assign flags_rd   = {any_err, flag_reg};

    always_comb begin
        rd_next = 32'h00000000;
        if (hit(paddr, `DMACS_IDX_CTRL)) begin
            rd_next[`DMACS_CTRL_W-1:0] = ctrl_reg;
        end else if (hit(paddr, `DMACS_IDX_STATE)) begin
            rd_next[7:0] = state_bits;
        end else if (hit(paddr, `DMACS_IDX_FLAGS)) begin
            rd_next[7:0] = flags_rd;
        end else if (hit(paddr, `DMACS_IDX_PTR)) begin
            rd_next[`DMACS_PTR_W-1:0] = ptr_reg;
        end else if (hit(paddr, `DMACS_IDX_CNT)) begin
            rd_next[`DMACS_CNT_W-1:0] = cnt_reg;
        end else if (hit(paddr, `DMACS_IDX_CAP_PTR)) begin
            rd_next[`DMACS_PTR_W-1:0] = cap_ptr_reg;
        end else if (hit(paddr, `DMACS_IDX_CAP_CNT)) begin
            rd_next[`DMACS_CNT_W-1:0] = cap_cnt_reg;
        end
    end

    // Read data captured in the setup cycle, stable through access
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata <= rd_next;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ***********************************************
    // Assertions
    // ***********************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_idle_flag_set: assert property (
        ctrl_reg[0] && channel_active_status ##1 !channel_active_status
        |=> flag_reg[`DMACS_FL_IDLE])
        else $error("idle flag not set on busy to idle");

    a_drain_flag_set: assert property (
        ctrl_reg[1] && pipeline_full_status ##1 !pipeline_full_status
        |=> flag_reg[`DMACS_FL_DRAIN])
        else $error("drain flag not set on full to busy");

    a_start_from_idle: assert property (
        start_wr && !channel_active_status && !err_block
        |=> channel_active_status && !pipeline_full_status)
        else $error("start from idle did not reach busy");

    a_start_to_full: assert property (
        start_wr && state_reg == dmacs_pkg::ST_BUSY && !err_block && !done
        |=> pipeline_full_status)
        else $error("start while busy did not set full");

    a_refuse_flag: assert property (
        start_wr && pipeline_full_status |=> flag_reg[`DMACS_FL_REJ])
        else $error("refused start not flagged");

    a_discard_pipe: assert property (
        discard_reg && done |=> !channel_active_status)
        else $error("discarded pipeline was started");

    a_late_paused: assert property (
        ctrl_reg[`DMACS_CTRL_PAUSE] && !flag_reg[`DMACS_FL_LATE] && !wr_ctrl
        |=> !flag_reg[`DMACS_FL_LATE])
        else $error("late flag set while paused");

    a_cap_parity: assert property (
        xfer_parity_event |=> cap_ptr_reg == $past(ptr_reg) && cap_cnt_reg == $past(cnt_reg))
        else $error("pointer not captured on parity error");

    a_flag_sticky: assert property (
        flag_reg[`DMACS_FL_TRANSFER_PARITY_FLAG] && !(wr_flags && pwdata[`DMACS_FL_TRANSFER_PARITY_FLAG])
        |=> flag_reg[`DMACS_FL_TRANSFER_PARITY_FLAG])
        else $error("parity flag lost without a write of one");

    a_ctrl_busy: assert property (
        wr_ctrl && channel_active_status |=> $stable(ctrl_reg) && flag_reg[`DMACS_FL_PIOE])
        else $error("control write while busy not refused");

    c_pipe_fill: cover property (
        state_reg == dmacs_pkg::ST_BUSY ##[1:50] pipeline_full_status);
    c_refused: cover property (refuse && channel_active_status);
    c_parity_idle: cover property (flag_reg[`DMACS_FL_TRANSFER_PARITY_FLAG] && done);

endmodule : dmacs_top

`default_nettype wire

// file: verification/dmacs_periph_model.sv
// Peripheral model on the channel handshake pins.
// Assumes the bench gives logical levels and pin polarity; clk_sys only.
`timescale 1ns/1ps
`default_nettype none

module dmacs_periph_model (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic req_on,
    input  wire logic ack_on,
    input  wire logic req_pol,
    input  wire logic ack_pol,
    output logic      peripheral_request,
    output logic      peripheral_acknowledge
);
    // ********************
    // Pin drive
    // ********************
    // Polarity bit set means the pin is active low
    always_ff @(posedge clk_sys) begin
        peripheral_request     <= sys_rst ? req_pol : (req_on ^ req_pol);
        peripheral_acknowledge <= sys_rst ? ack_pol : (ack_on ^ ack_pol);
    end
endmodule : dmacs_periph_model

`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench of the channel status block against a flag model.
// Assumes dmacs_regs.svh and the peripheral model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dmacs_regs.svh"

module tb_top;
    localparam logic [11:0] A_CTL = {`DMACS_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_CMD = {`DMACS_IDX_CMD, 2'b00};
    localparam logic [11:0] A_ST  = {`DMACS_IDX_STATE, 2'b00};
    localparam logic [11:0] A_FL  = {`DMACS_IDX_FLAGS, 2'b00};
    localparam logic [11:0] A_PTR = {`DMACS_IDX_PTR, 2'b00};
    localparam logic [11:0] A_CNT = {`DMACS_IDX_CNT, 2'b00};
    localparam logic [11:0] A_CP  = {`DMACS_IDX_CAP_PTR, 2'b00};
    localparam logic [11:0] A_CC  = {`DMACS_IDX_CAP_CNT, 2'b00};
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [4:0]  ev      = 5'h00;
    logic        fifo    = 1'b0;
    logic        pio     = 1'b0;
    logic        crst    = 1'b0;
    logic        req_on  = 1'b0;
    logic        ack_on  = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rq_pin;
    logic        ak_pin;
    logic        act;
    logic        full;
    logic        chan_irq;
    logic        err_seen;
    int          mismatches = 0;
    int          checked    = 0;
    int          cyc        = 0;
    int          mp, mc, np, nc, ma, mf, md, mfl, mctl, cp, cc, i, v;

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    dmacs_top dmacs_top_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .peripheral_request(rq_pin),
        .peripheral_acknowledge(ak_pin), .fifo_empty_status(fifo),
        .xfer_byte(ev[0]), .fifo_late_event(ev[1]), .xfer_parity_event(ev[2]),
        .pio_active(pio), .chan_reset_active(crst), .pio_request(ev[3]),
        .pio_parity_event(ev[4]), .channel_active_status(act),
        .pipeline_full_status(full), .chan_irq(chan_irq)
    );

    dmacs_periph_model dmacs_periph_model_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .req_on(req_on), .ack_on(ack_on),
        .req_pol(mctl[3]), .ack_pol(mctl[4]), .peripheral_request(rq_pin),
        .peripheral_acknowledge(ak_pin)
    );

    // ********************
    // Checks and bus cycles
    // ********************
    task automatic give_verdict();
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        q = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic wr(input logic [11:0] a, input int d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rc(input logic [11:0] a, input int e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rc

    // ********************
    // Reference model
    // ********************
    function automatic int fx();
        return mfl | (((mfl & 'h7C) != 0) << 7);
    endfunction : fx

    task automatic cf();
        rc(A_FL, fx());
        chk(chan_irq, mfl != 0);
    endtask : cf

    task automatic ss();
        repeat (4) @(posedge clk_sys);
        rc(A_ST, ma | mf << 1 | fifo << 2 | (pio | crst) << 3 | req_on << 4 | ack_on << 5);
        chk(act, ma);
        chk(full, mf);
    endtask : ss

    task automatic pulse(input int b);
        // Whole-vector write keeps the automatic index out of the NBA target
        ev <= 5'h01 << b;
        @(posedge clk_sys);
        ev <= 5'h00;
        repeat (2) @(posedge clk_sys);
    endtask : pulse

    task automatic byt(input int n);
        repeat (n) begin
            pulse(0);
            if (ma) begin
                mp = (mp + 1) & 'hFFFFF;
                if (mc == 1) begin
                    if (mf && !md && !(mfl & 4)) begin
                        mp = np;
                        mc = nc;
                        mfl |= mctl & 2;
                    end else begin
                        ma = 0;
                        mfl |= mctl & 1;
                    end
                    mf = 0;
                    md = 0;
                end else
                    mc = (mc - 1) & 'hFFFF;
            end
        end
    endtask : byt

    task automatic ld(input int p, input int c);
        wr(A_PTR, p);
        wr(A_CNT, c);
        if (!ma) begin
            mp = p;
            mc = c;
        end else if (!mf) begin
            np = p;
            nc = c;
        end
    endtask : ld

    task automatic st();
        wr(A_CMD, 1);
        if (mf || (mfl & 'hC)) begin
            mfl |= 'h10;
            if (ma) md = 1;
        end else if (ma)
            mf = 1;
        else
            ma = 1;
        @(posedge clk_sys);
    endtask : st

    task automatic cw(input int d);
        wr(A_CTL, d);
        if (ma) mfl |= 'h20;
        else mctl = d;
    endtask : cw

    task automatic fc(input int d);
        wr(A_FL, d);
        mfl &= ~d;
    endtask : fc

    // ********************
    // Main sequence
    // ********************
    initial begin
        v = $urandom(88752);
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        cf();
        ss();
        for (i = 0; i < 12; i++) begin
            v = $urandom;
            req_on <= v[0];
            ack_on <= v[1];
            fifo   <= v[2];
            pio    <= v[3];
            crst   <= v[4];
            cw((v >> 3) & 'h18);
            ss();
        end
        pio  <= 1'b0;
        crst <= 1'b0;
        cw(3);
        ld($urandom & 'hFFFFF, 3);
        rc(A_PTR, mp);
        st();
        ss();
        ld((mp + 'h100) & 'hFFFFF, 2);
        rc(A_CNT, mc);
        st();
        ss();
        ld(5, 5);
        byt(3);
        ss();
        rc(A_PTR, mp);
        cf();
        fc(0);
        cf();
        fc(2);
        byt(2);
        cf();
        fc('hFF);
        cf();
        cw(0);
        ld('h200, 2);
        st();
        ld('h300, 4);
        st();
        st();
        cf();
        ss();
        byt(2);
        ss();
        rc(A_PTR, mp);
        fc('hFF);
        ld('h400, 6);
        st();
        byt(2);
        cw(4);
        rc(A_CTL, mctl);
        pulse(2);
        mfl |= 4;
        cp = mp;
        cc = mc;
        rc(A_CP, cp);
        rc(A_CC, cc);
        ld('h500, 3);
        st();
        cf();
        byt(3);
        ss();
        byt(1);
        ss();
        fc('hFF);
        for (i = 0; i < 2; i++) begin
            cw(i * 4);
            ld('h600, 3);
            st();
            pulse(1);
            if (!mctl[2]) mfl |= 8;
            cf();
            byt(3);
            pulse(1);
            cf();
            fc('hFF);
        end
        for (i = 0; i < 2; i++) begin
            cw(i * 'h20);
            pulse(3);
            if (mctl[5]) mfl |= 'h20;
            cf();
        end
        cw(0);
        ld('h700, 2);
        st();
        pulse(4);
        mfl |= 'h40;
        ss();
        cf();
        byt(2);
        rc(12'hFFC, 0);
        chk(err_seen, 1);
        give_verdict();
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
endmodule : tb_top

`default_nettype wire
